// File: design/frc_pkg.sv
/*
  Shared constants and types for the remote-register command interpreter.
  Assumes a 16-bit remote register word and an 8-word double-width station map.
*/
package frc_pkg;

  // Master-to-drive word indices.
  localparam logic [2:0] MONITOR_CODE_PAIR_IDX = 3'h0;
  localparam logic [2:0] DRIVE_COMMAND_VALUE_IDX = 3'h1;
  localparam logic [2:0] COMMAND_CODE_WORD_IDX = 3'h2;
  localparam logic [2:0] COMMAND_WRITE_DATA_IDX = 3'h3;
  localparam logic [2:0] MONITOR_CODE_THREE_IDX = 3'h4;
  localparam logic [2:0] MONITOR_CODE_FOUR_IDX = 3'h5;
  localparam logic [2:0] MONITOR_CODE_FIVE_IDX = 3'h6;
  localparam logic [2:0] MONITOR_CODE_SIX_IDX = 3'h7;

  // Drive-to-master word indices.
  localparam int unsigned RD_MONITOR_ONE_IDX = 0;
  localparam int unsigned RD_MONITOR_TWO_IDX = 1;
  localparam int unsigned RD_RESPONSE_IDX = 2;
  localparam int unsigned RD_READ_DATA_IDX = 3;
  localparam int unsigned RD_MONITOR_THREE_IDX = 4;
  localparam int unsigned NUM_WORDS = 8;
  localparam int unsigned NUM_MONITORS = 6;

  // Reset value of every register word.
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // Response codes.
  localparam logic [15:0] RESP_OK = 16'h0000;
  localparam logic [15:0] RESP_WRITE_MODE_ERR = 16'h0001;
  localparam logic [15:0] RESP_SELECT_ERR = 16'h0002;
  localparam logic [15:0] RESP_RANGE_ERR = 16'h0003;

  // Command word field positions.
  localparam int unsigned CMD_GROUP_MSB = 15;
  localparam int unsigned CMD_GROUP_LSB = 8;
  localparam int unsigned CMD_WRITE_BIT = 7;
  localparam int unsigned CMD_NUMBER_MSB = 6;
  localparam logic [6:0] CMD_NUMBER_MAX = 7'h63;

  // Parameter group identifiers.
  localparam logic [7:0] GRP_FUNDAMENTAL = 8'h00;
  localparam logic [7:0] GRP_TERMINAL = 8'h01;
  localparam logic [7:0] GRP_CONTROL = 8'h02;
  localparam logic [7:0] GRP_MOTOR1 = 8'h03;
  localparam logic [7:0] GRP_HIGH_PERF = 8'h04;
  localparam logic [7:0] GRP_MOTOR23 = 8'h05;
  localparam logic [7:0] GRP_OPTION = 8'h06;
  localparam logic [7:0] GRP_COMM_CMD = 8'h07;
  localparam logic [7:0] GRP_COMM_MON = 8'h08;
  localparam logic [7:0] GRP_ELEVATOR = 8'h09;
  localparam logic [7:0] GRP_USER = 8'h0B;
  localparam logic [7:0] GRP_TERMINAL_EXT = 8'h1E;
  localparam logic [7:0] GRP_HIGH_PERF_EXT1 = 8'h1F;
  localparam logic [7:0] GRP_HIGH_PERF_EXT2 = 8'h20;
  localparam logic [7:0] GRP_MOTOR23_EXT = 8'h24;
  localparam logic [7:0] GRP_OPTION_EXT = 8'h25;
  localparam logic [7:0] GRP_USER_EXT = 8'h27;
  localparam logic [7:0] GRP_SAFETY = 8'h28;
  localparam logic [7:0] GRP_MONITOR_EXT1 = 8'h29;
  localparam logic [7:0] GRP_MONITOR_EXT2 = 8'h2A;

  // Command value limits and torque source value for link torque.
  localparam logic signed [15:0] CMD_VALUE_MAX = 16'sh4E20;
  localparam logic signed [15:0] CMD_VALUE_MIN = -16'sh4E20;
  localparam logic [7:0] TORQUE_SRC_LINK = 8'h04;

  // Decoded command word.
  typedef struct packed {
    logic [7:0] group;
    logic write;
    logic [6:0] number;
  } frc_cmd_fields_t;

  // Group classification.
  typedef struct packed {
    logic known;
    logic read_only;
    logic comm_cmd;
  } frc_group_class_t;

  // Request to the drive parameter store.
  typedef struct packed {
    frc_cmd_fields_t sel;
    logic [15:0] wdata;
  } frc_param_req_t;

  // Answer from the drive parameter store.
  typedef struct packed {
    logic exists;
    logic read_only;
    logic in_range;
    logic [15:0] rdata;
  } frc_param_resp_t;

  // Command value applied to the drive.
  typedef struct packed {
    logic torque_mode;
    logic signed [15:0] value;
  } frc_drive_cmd_t;

endpackage : frc_pkg

// File: design/frc_code_decode.sv
/*
  Splits a command word into group, direction and number, and classifies the group.
  Purely combinational; assumes the caller registers whatever it needs.
*/
`timescale 1ns/1ps
module frc_code_decode
  import frc_pkg::*;
(
  // Command word.
  input wire logic [15:0] code_in,
  // Decoded fields and group class.
  output frc_cmd_fields_t fields_out,
  output frc_group_class_t class_out
);

  // Field split of the command word.
  // field split
  assign fields_out.group = code_in[CMD_GROUP_MSB:CMD_GROUP_LSB];
  assign fields_out.write = code_in[CMD_WRITE_BIT];
  assign fields_out.number = code_in[CMD_NUMBER_MSB:0];

  // Fixed group table; monitor and safety groups are read-only.
  always_comb begin
    class_out = '0;
    case (code_in[CMD_GROUP_MSB:CMD_GROUP_LSB])
      GRP_FUNDAMENTAL, GRP_TERMINAL, GRP_CONTROL, GRP_MOTOR1, GRP_HIGH_PERF,
      GRP_MOTOR23, GRP_OPTION, GRP_ELEVATOR, GRP_USER, GRP_TERMINAL_EXT,
      GRP_HIGH_PERF_EXT1, GRP_HIGH_PERF_EXT2, GRP_MOTOR23_EXT, GRP_OPTION_EXT,
      GRP_USER_EXT: begin
        class_out.known = 1'b1;
      end
      GRP_COMM_CMD: begin
        class_out.known = 1'b1;
        class_out.comm_cmd = 1'b1;
      end
      GRP_COMM_MON, GRP_MONITOR_EXT1, GRP_MONITOR_EXT2, GRP_SAFETY: begin
        class_out.known = 1'b1;
        class_out.read_only = 1'b1;
      end
      default: begin
        class_out = '0;
      end
    endcase
  end

endmodule : frc_code_decode

// File: design/frc_remote_cmd.sv
/*
  Remote-register command interpreter for the double-width single-station mode.
  Assumes master words arrive as single-cycle word writes synchronous to core_clk_in,
  request bits are synchronous levels, and the drive answers parameter requests
  with a one-cycle acknowledge carrying existence, access and range flags.
*/
`timescale 1ns/1ps
module frc_remote_cmd
  import frc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Master-to-drive word writes.
  input wire logic word_wr_in,
  input wire logic [2:0] word_idx_in,
  input wire logic [15:0] word_data_in,
  // Remote request bits and their done answers.
  input wire logic monitor_latch_request_in,
  input wire logic speed_apply_request_in,
  input wire logic command_execute_request_in,
  output logic speed_apply_done_out,
  output logic command_done_out,
  // Drive-to-master words.
  output logic [15:0] drive_to_master_word_out [NUM_WORDS],
  // Monitor selection and sampled values.
  output logic [7:0] monitor_code_out [NUM_MONITORS],
  input wire logic [15:0] monitor_value_in [NUM_MONITORS],
  // Drive state that gates parameter writes, and the torque source select.
  input wire logic drive_running_in,
  input wire logic nvm_busy_in,
  input wire logic tx_error_in,
  input wire logic loader_link_active_in,
  input wire logic edit_locked_in,
  input wire logic [7:0] torque_source_select_in,
  // Command value toward the drive.
  output frc_drive_cmd_t drive_cmd_out,
  output logic drive_cmd_apply_out,
  // Parameter store access (volatile memory only).
  output frc_param_req_t param_req_out,
  output logic param_req_valid_out,
  input wire logic param_ack_in,
  input wire frc_param_resp_t param_resp_in
);

  // Command state machine.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_ACCESS = 4'b0100,
    ST_DONE = 4'b1000
  } frc_state_t;

  // Master-written words.
  logic [15:0] master_to_drive_word_reg [NUM_WORDS];
  // Edge history of the request bits.
  logic monitor_req_prev_reg;
  logic speed_req_prev_reg;
  logic cmd_req_prev_reg;
  // Command tracking.
  frc_state_t state_reg;
  frc_state_t state_next;
  frc_cmd_fields_t fields;
  frc_group_class_t group_class;
  logic [15:0] response_code_reg;
  logic [15:0] read_data_reg;
  logic [15:0] monitor_hold_reg [NUM_MONITORS];
  logic speed_apply_done_reg;
  logic speed_pending_reg;
  logic [15:0] code_latched_reg;
  logic [15:0] wdata_latched_reg;
  logic monitor_latch_rise;
  logic speed_apply_rise;
  logic cmd_exec_rise;
  logic write_blocked;

  // Clamps a signed command value into the legal span.
  function automatic logic signed [15:0] clamp_cmd(input logic signed [15:0] v);
    if (v > CMD_VALUE_MAX) begin
      return CMD_VALUE_MAX;
    end else if (v < CMD_VALUE_MIN) begin
      return CMD_VALUE_MIN;
    end
    return v;
  endfunction : clamp_cmd

  // Rising edge of a request level against its previous sample.
  function automatic logic rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction : rise

  // Decoder for the latched command word.
  frc_code_decode u_decode (
    .code_in(code_latched_reg),
    .fields_out(fields),
    .class_out(group_class)
  );

  // Request edges.
  assign monitor_latch_rise = rise(monitor_latch_request_in, monitor_req_prev_reg);
  assign speed_apply_rise = rise(speed_apply_request_in, speed_req_prev_reg);
  assign cmd_exec_rise = rise(command_execute_request_in, cmd_req_prev_reg);

  // Request history.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      monitor_req_prev_reg <= 1'b0;
      speed_req_prev_reg <= 1'b0;
      cmd_req_prev_reg <= 1'b0;
    end else begin
      monitor_req_prev_reg <= monitor_latch_request_in;
      speed_req_prev_reg <= speed_apply_request_in;
      cmd_req_prev_reg <= command_execute_request_in;
    end
  end

  // Master word storage; the master owns these words outright.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        master_to_drive_word_reg[i] <= WORD_RESET;
      end
    end else if (word_wr_in) begin
      master_to_drive_word_reg[word_idx_in] <= word_data_in;
    end
  end

  // Monitor code selection toward the drive.
  always_comb begin
    monitor_code_out[0] = master_to_drive_word_reg[MONITOR_CODE_PAIR_IDX][7:0];
    monitor_code_out[1] = master_to_drive_word_reg[MONITOR_CODE_PAIR_IDX][15:8];
    monitor_code_out[2] = master_to_drive_word_reg[MONITOR_CODE_THREE_IDX][7:0];
    monitor_code_out[3] = master_to_drive_word_reg[MONITOR_CODE_FOUR_IDX][7:0];
    monitor_code_out[4] = master_to_drive_word_reg[MONITOR_CODE_FIVE_IDX][7:0];
    monitor_code_out[5] = master_to_drive_word_reg[MONITOR_CODE_SIX_IDX][7:0];
  end

  // Monitor latch: values are captured on the rising edge of the request.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < NUM_MONITORS; i++) begin
        monitor_hold_reg[i] <= WORD_RESET;
      end
    end else if (monitor_latch_rise) begin
      for (int i = 0; i < NUM_MONITORS; i++) begin
        monitor_hold_reg[i] <= monitor_value_in[i];
      end
    end
  end

  // Speed or torque command apply and its done bit.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      drive_cmd_out <= '0;
      drive_cmd_apply_out <= 1'b0;
      speed_pending_reg <= 1'b0;
      speed_apply_done_reg <= 1'b0;
    end else begin
      drive_cmd_apply_out <= 1'b0;
      if (speed_apply_rise) begin
        drive_cmd_out.value <= clamp_cmd(master_to_drive_word_reg[DRIVE_COMMAND_VALUE_IDX]);
        drive_cmd_out.torque_mode <= (torque_source_select_in == TORQUE_SRC_LINK);
        drive_cmd_apply_out <= 1'b1;
        speed_pending_reg <= 1'b1;
      end else if (speed_pending_reg) begin
        speed_pending_reg <= 1'b0;
        speed_apply_done_reg <= speed_apply_request_in;
      end else if (!speed_apply_request_in) begin
        speed_apply_done_reg <= 1'b0;
      end
    end
  end

  assign speed_apply_done_out = speed_apply_done_reg;

  // Write is refused while the drive cannot accept edits.
  // write mode gating
  assign write_blocked = drive_running_in | nvm_busy_in | tx_error_in | edit_locked_in
                       | (loader_link_active_in & group_class.comm_cmd);

  // Command state transitions.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_exec_rise) begin
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (!group_class.known || fields.number > CMD_NUMBER_MAX
            || (fields.write && (group_class.read_only || write_blocked))) begin
          state_next = ST_DONE;
        end else begin
          state_next = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (param_ack_in) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!command_execute_request_in) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Command and data are frozen when execution starts.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      code_latched_reg <= WORD_RESET;
      wdata_latched_reg <= WORD_RESET;
    end else if (state_reg == ST_IDLE && cmd_exec_rise) begin
      code_latched_reg <= master_to_drive_word_reg[COMMAND_CODE_WORD_IDX];
      wdata_latched_reg <= master_to_drive_word_reg[COMMAND_WRITE_DATA_IDX];
    end
  end

  // Parameter store request; the store holds written data in volatile memory only.
  always_comb begin
    param_req_out.sel = fields;
    param_req_out.wdata = wdata_latched_reg;
    param_req_valid_out = (state_reg == ST_ACCESS);
  end

  // Response code and read data.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      response_code_reg <= RESP_OK;
      read_data_reg <= WORD_RESET;
    end else if (state_reg == ST_CHECK) begin
      if (!group_class.known || fields.number > CMD_NUMBER_MAX) begin
        response_code_reg <= RESP_SELECT_ERR;
      end else if (fields.write && group_class.read_only) begin
        response_code_reg <= RESP_SELECT_ERR;
      end else if (fields.write && write_blocked) begin
        response_code_reg <= RESP_WRITE_MODE_ERR;
      end
    end else if (state_reg == ST_ACCESS && param_ack_in) begin
      if (!param_resp_in.exists || (fields.write && param_resp_in.read_only)) begin
        response_code_reg <= RESP_SELECT_ERR;
      end else if (fields.write && !param_resp_in.in_range) begin
        response_code_reg <= RESP_RANGE_ERR;
      end else begin
        response_code_reg <= RESP_OK;
        if (!fields.write) begin
          read_data_reg <= param_resp_in.rdata;
        end
      end
    end
  end

  // Command done holds while the request stays high.
  // done handshake
  assign command_done_out = (state_reg == ST_DONE) & ~cmd_exec_rise;

  // Drive-to-master word map.
  always_comb begin
    drive_to_master_word_out[RD_MONITOR_ONE_IDX] = monitor_hold_reg[0];
    drive_to_master_word_out[RD_MONITOR_TWO_IDX] = monitor_hold_reg[1];
    drive_to_master_word_out[RD_RESPONSE_IDX] = response_code_reg;
    drive_to_master_word_out[RD_READ_DATA_IDX] = read_data_reg;
    for (int i = 2; i < NUM_MONITORS; i++) begin
      drive_to_master_word_out[RD_MONITOR_THREE_IDX + i - 2] = monitor_hold_reg[i];
    end
  end

endmodule : frc_remote_cmd

// File: verification/frc_store_model.sv
/*
  Parameter store model that answers the interpreter's access handshake.
  Assumes one request at a time, held until it is acknowledged.
*/
`timescale 1ns/1ps
module frc_store_model
  import frc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Access handshake.
  input wire logic req_valid_in,
  input wire frc_param_req_t req_in,
  input wire logic slow_in,
  output logic ack_out,
  output frc_param_resp_t resp_out
);
  logic [3:0] wait_reg;

  // Waits zero or six cycles, then pulses the acknowledge once.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_reg <= 4'h0;
      ack_out <= 1'b0;
    end else if (req_valid_in && !ack_out && wait_reg >= (slow_in ? 4'h6 : 4'h0)) begin
      ack_out <= 1'b1;
      wait_reg <= 4'h0;
    end else begin
      ack_out <= 1'b0;
      wait_reg <= (req_valid_in && !ack_out) ? wait_reg + 4'h1 : 4'h0;
    end
  end

  always_comb begin
    resp_out.exists = req_in.sel.number != 7'h50;
    resp_out.read_only = req_in.sel.number == 7'h01;
    resp_out.in_range = req_in.wdata < 16'h1000;
    resp_out.rdata = {req_in.sel.group, 1'b0, req_in.sel.number};
    if (!ack_out) begin
      resp_out.rdata = ~resp_out.rdata; // Garbled outside the acknowledge.
    end
  end
endmodule : frc_store_model

// File: verification/frc_remote_cmd_props.sv
/*
  Port checker for the remote command interpreter.
  Assumes it is bound to frc_remote_cmd and sees only its ports.
*/
`timescale 1ns/1ps
module frc_remote_cmd_props
  import frc_pkg::*;
(
  // Watched ports.
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic word_wr_in,
  input wire logic [2:0] word_idx_in,
  input wire logic [15:0] word_data_in,
  input wire logic monitor_latch_request_in,
  input wire logic speed_apply_request_in,
  input wire logic command_execute_request_in,
  input wire logic speed_apply_done_out,
  input wire logic command_done_out,
  input wire logic [15:0] drive_to_master_word_out [NUM_WORDS],
  input wire logic [7:0] monitor_code_out [NUM_MONITORS],
  input wire logic [15:0] monitor_value_in [NUM_MONITORS],
  input wire logic [7:0] torque_source_select_in,
  input wire frc_drive_cmd_t drive_cmd_out,
  input wire logic drive_cmd_apply_out,
  input wire frc_param_req_t param_req_out,
  input wire logic param_req_valid_out,
  input wire logic param_ack_in,
  input wire frc_param_resp_t param_resp_in
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  // Port relations over time.
  AST_MON_CODES: assert property (word_wr_in && word_idx_in == 3'h0 |=>
    monitor_code_out[0] == $past(word_data_in[7:0]) &&
    monitor_code_out[1] == $past(word_data_in[15:8])) else $error("Monitor codes wrong.");
  AST_LATCH: assert property ($rose(monitor_latch_request_in) |=>
    drive_to_master_word_out[0] == $past(monitor_value_in[0]) &&
    drive_to_master_word_out[7] == $past(monitor_value_in[5])) else $error("Latch wrong.");
  AST_APPLY: assert property ($rose(speed_apply_request_in) |=>
    drive_cmd_apply_out ##1 !drive_cmd_apply_out) else $error("Apply pulse wrong.");
  AST_CLAMP: assert property (drive_cmd_apply_out |->
    $signed(drive_cmd_out.value) <= CMD_VALUE_MAX && $signed(drive_cmd_out.value) >= CMD_VALUE_MIN)
    else $error("Command value out of range.");
  AST_TORQUE: assert property (drive_cmd_apply_out |->
    drive_cmd_out.torque_mode == ($past(torque_source_select_in) == TORQUE_SRC_LINK))
    else $error("Torque mode wrong.");
  AST_SPD_CLR: assert property (speed_apply_done_out && !speed_apply_request_in |=>
    !speed_apply_done_out) else $error("Apply done not cleared.");
  AST_CMD_HOLD: assert property (command_done_out && command_execute_request_in |=>
    command_done_out) else $error("Command done dropped early.");
  AST_CMD_BOUND: assert property ($rose(command_execute_request_in) && !command_done_out
    |-> ##[2:40] command_done_out) else $error("Command never done.");
  AST_REQ_HOLD: assert property (param_req_valid_out && !param_ack_in |=>
    param_req_valid_out && $stable(param_req_out)) else $error("Store request moved.");
  AST_RO_GROUP: assert property (param_req_valid_out && param_req_out.sel.write |->
    !(param_req_out.sel.group inside {8'h08, 8'h28, 8'h29, 8'h2A}))
    else $error("Read-only group write reached store.");
  AST_SEL_ERR: assert property (param_req_valid_out && param_ack_in &&
    !param_resp_in.exists |=> drive_to_master_word_out[2] == RESP_SELECT_ERR)
    else $error("Selection code wrong.");
  AST_RANGE: assert property (param_req_valid_out && param_ack_in && param_resp_in.exists &&
    param_req_out.sel.write && !param_resp_in.read_only && !param_resp_in.in_range
    |=> drive_to_master_word_out[2] == RESP_RANGE_ERR) else $error("Range code wrong.");
  AST_READ: assert property (param_req_valid_out && param_ack_in && param_resp_in.exists &&
    !param_req_out.sel.write |=> drive_to_master_word_out[2] == RESP_OK &&
    drive_to_master_word_out[3] == $past(param_resp_in.rdata)) else $error("Read wrong.");
endmodule : frc_remote_cmd_props

// File: verification/tb.sv
/*
  Self-checking bench for the remote command interpreter and its store model.
  Assumes a 100 MHz clock and inputs driven 1 ns after each rising edge.
*/
`timescale 1ns/1ps
module tb
  import frc_pkg::*;
();
  logic clk, arst_n, wr, lat, spd, cmd, run, nvm, txe, ldr, lock, slow, ack, apply, pvalid;
  logic spd_done, cmd_done;
  logic [2:0] idx;
  logic [15:0] data;
  logic [7:0] tsrc;
  logic [15:0] words [NUM_WORDS];
  logic [7:0] codes [NUM_MONITORS];
  logic [15:0] mon_val [NUM_MONITORS];
  frc_drive_cmd_t dcmd;
  frc_param_req_t preq;
  frc_param_resp_t resp;
  int n_fail, n_tests, cyc;

  frc_remote_cmd i_dut (.core_clk_in(clk), .arst_n_in(arst_n), .word_wr_in(wr),
    .word_idx_in(idx), .word_data_in(data), .monitor_latch_request_in(lat),
    .speed_apply_request_in(spd), .command_execute_request_in(cmd),
    .speed_apply_done_out(spd_done), .command_done_out(cmd_done),
    .drive_to_master_word_out(words), .monitor_code_out(codes), .monitor_value_in(mon_val),
    .drive_running_in(run), .nvm_busy_in(nvm), .tx_error_in(txe),
    .loader_link_active_in(ldr), .edit_locked_in(lock), .torque_source_select_in(tsrc),
    .drive_cmd_out(dcmd), .drive_cmd_apply_out(apply), .param_req_out(preq),
    .param_req_valid_out(pvalid), .param_ack_in(ack), .param_resp_in(resp));
  frc_store_model i_store (.core_clk_in(clk), .arst_n_in(arst_n), .req_valid_in(pvalid),
    .req_in(preq), .slow_in(slow), .ack_out(ack), .resp_out(resp));

  // Clock and hang guard.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task tick; @(posedge clk); #1; endtask : tick
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task wr_word(input logic [2:0] i, input logic [15:0] d);
    wr = 1'b1;
    idx = i;
    data = d;
    tick();
    // Let one edge pass with the strobe low so that back-to-back writes never retoggle it.
    wr = 1'b0;
    tick();
  endtask : wr_word

  task t_monitor;
    for (int k = 0; k < 8; k++) check(words[k], WORD_RESET); // Reset values.
    wr_word(3'h0, 16'h2B1A);
    for (int k = 4; k < 8; k++) wr_word(3'(k), 16'(16'h0030 + k));
    check(codes[0], 8'h1A);
    check(codes[1], 8'h2B);
    for (int k = 2; k < 6; k++) check(codes[k], 8'(8'h32 + k));
    for (int k = 0; k < 6; k++) mon_val[k] = 16'(16'hC000 + k);
    lat = 1'b1; tick();
    for (int k = 0; k < 6; k++) mon_val[k] = 16'h0000; // Later values must not leak in.
    tick();
    for (int k = 0; k < 6; k++) check(words[k < 2 ? k : k + 2], 16'(16'hC000 + k));
    lat = 1'b0; tick();
    $display("monitor test done");
  endtask : t_monitor

  task apply_one(input logic [15:0] v, input logic [7:0] src, input logic [16:0] exp);
    int i;
    wr_word(3'h1, v); tsrc = src; spd = 1'b1;
    for (i = 0; i < 10 && apply !== 1'b1; i++) tick();
    check(apply, 1'b1);
    check(dcmd, exp);
    tick(); check(spd_done, 1'b1);
    spd = 1'b0; tick(); tick(); check(spd_done, 1'b0);
  endtask : apply_one

  task t_apply;
    apply_one(16'h0064, 8'h00, {1'b0, 16'h0064});
    apply_one(16'hB1E0, 8'h04, {1'b1, 16'hB1E0});
    apply_one(16'h61A8, 8'h03, {1'b0, 16'h4E20});
    apply_one(16'h8000, 8'h04, {1'b1, 16'hB1E0});
    $display("apply test done");
  endtask : t_apply

  task run_cmd(input logic [15:0] code, input logic [15:0] d, input logic [15:0] exp);
    logic [15:0] prev;
    int i;
    prev = words[3];
    wr_word(3'h2, code); wr_word(3'h3, d); cmd = 1'b1;
    for (i = 0; i < 40 && cmd_done !== 1'b1; i++) begin
      tick();
      if (pvalid === 1'b1) check(preq, {code, d});
    end
    check(cmd_done, 1'b1);
    check(words[2], exp);
    check(words[3], (exp == RESP_OK && !code[7]) ? {code[15:8], 1'b0, code[6:0]} : prev);
    cmd = 1'b0; tick(); tick(); check(cmd_done, 1'b0);
  endtask : run_cmd

  task t_cmds;
    run_cmd(16'h0105, 16'h0000, RESP_OK);
    slow = 1'b1; run_cmd(16'h291A, 16'h0000, RESP_OK); slow = 1'b0;
    run_cmd(16'h1E82, 16'h0005, RESP_OK);
    run_cmd(16'h1E82, 16'h2000, RESP_RANGE_ERR);
    run_cmd(16'h0481, 16'h0001, RESP_SELECT_ERR);
    run_cmd(16'h0050, 16'h0000, RESP_SELECT_ERR);
    run_cmd(16'h0064, 16'h0000, RESP_SELECT_ERR);
    run_cmd(16'h0A01, 16'h0000, RESP_SELECT_ERR);
    run_cmd(16'h0881, 16'h0005, RESP_SELECT_ERR);
    for (int b = 0; b < 4; b++) begin
      {run, nvm, txe, lock} = 4'(4'h1 << b);
      run_cmd(16'h0187, 16'h0005, RESP_WRITE_MODE_ERR);
      run_cmd(16'h2881, 16'h0005, RESP_SELECT_ERR);
      run_cmd(16'h0105, 16'h0000, RESP_OK);
    end
    {run, nvm, txe, lock} = 4'h0; ldr = 1'b1;
    run_cmd(16'h0787, 16'h0005, RESP_WRITE_MODE_ERR);
    run_cmd(16'h0187, 16'h0005, RESP_OK);
    run_cmd(16'h0707, 16'h0000, RESP_OK);
    ldr = 1'b0;
    $display("command test done");
  endtask : t_cmds

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence.
  initial begin
    {clk, arst_n, wr, lat, spd, cmd, run, nvm, txe, ldr, lock, slow} = 12'h000;
    idx = 3'h0; data = 16'h0000; tsrc = 8'h00;
    for (int k = 0; k < 6; k++) mon_val[k] = 16'h0000;
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    t_monitor();
    t_apply();
    t_cmds();
    report_and_stop();
  end
endmodule : tb

bind frc_remote_cmd frc_remote_cmd_props i_props (.core_clk_in(core_clk_in),
  .arst_n_in(arst_n_in), .word_wr_in(word_wr_in), .word_idx_in(word_idx_in),
  .word_data_in(word_data_in), .monitor_latch_request_in(monitor_latch_request_in),
  .speed_apply_request_in(speed_apply_request_in),
  .command_execute_request_in(command_execute_request_in),
  .speed_apply_done_out(speed_apply_done_out), .command_done_out(command_done_out),
  .drive_to_master_word_out(drive_to_master_word_out), .monitor_code_out(monitor_code_out),
  .monitor_value_in(monitor_value_in), .torque_source_select_in(torque_source_select_in),
  .drive_cmd_out(drive_cmd_out), .drive_cmd_apply_out(drive_cmd_apply_out),
  .param_req_out(param_req_out), .param_req_valid_out(param_req_valid_out),
  .param_ack_in(param_ack_in), .param_resp_in(param_resp_in));
